// ### bench/tb_timer_wordswap_cycle_regs.sv
// Self-checking bench for the timer, word-order and cycle counter bank.
`timescale 1ns/1ps
module tb_timer_wordswap_cycle_regs;
	reg sys_clk_i = 0;
	reg resetn_i = 0;
	reg bus_16bit_i = 0;
	reg [31:0] tx_word_i = 0;
	reg tx_word_valid_i = 0;
	reg [15:0] rx_half_i = 0;
	reg rx_half_valid_i = 0;
	wire [7:0] addr_i;
	wire wr_i, rd_i, half_high_o, tx_word_ready_o, tx_half_valid_o;
	wire rx_word_valid_o, timer_event_o;
	wire [31:0] wdata_i, rdata_o, rx_word_o;
	wire [15:0] tx_half_o;
	integer err_total = 0, cmp_count = 0, cyc = 0, t0, tp = 0, te = 0;
	reg [31:0] v, w;
	always #2 sys_clk_i = ~sys_clk_i;
	always @(posedge sys_clk_i)
	begin
		cyc = cyc + 1;
		if (cyc > 20000)
		begin
			err_total = err_total + 1;
			end_of_test;
		end
	end
	tws_regs dut (.*);
	tws_host host (.sys_clk_i, .rdata_i(rdata_o), .addr_o(addr_i),
		.wr_o(wr_i), .rd_o(rd_i), .wdata_o(wdata_i));
	task chk(input [31:0] g, input [31:0] e);
	begin
		cmp_count = cmp_count + 1;
		if (g !== e)
		begin
			err_total = err_total + 1;
			$display("[ERR] %0t got %h expected %h", $time, g, e);
		end
	end
	endtask
	task rc(input [7:0] a, input [31:0] e);
	begin
		host.rd(a, v);
		chk(v, e);
	end
	endtask
	task ev;
	begin
		@(negedge sys_clk_i);
		t0 = cyc;
		while (timer_event_o !== 1'b1 && cyc - t0 < 1000)
			@(negedge sys_clk_i);
		tp = te;
		te = cyc;
	end
	endtask
	task end_of_test;
	begin
		$display("mismatches %0d compares %0d", err_total, cmp_count);
		if (err_total == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	end
	endtask
	initial
	begin
		repeat (2) @(negedge sys_clk_i);
		resetn_i = 1;
		rc(8'h8c, 32'h0000ffff);
		rc(8'h90, 32'h0000ffff);
		rc(8'h98, 32'h00000000);
		rc(8'h00, 32'h00000000);
		host.wr(8'h90, 32'h00000000);
		rc(8'h90, 32'h0000ffff);
		host.rd(8'h9c, v);
		repeat (97) @(negedge sys_clk_i);
		host.rd(8'h9c, w);
		chk(w - v, 32'h0000000a);
		bus_16bit_i = 1;
		host.rd(8'h9c, v);
		repeat (97) @(negedge sys_clk_i);
		rc(8'h9e, v);
		host.wr(8'h98, 32'hffffffff);
		#1 chk(half_high_o, 1);
		@(negedge sys_clk_i) bus_16bit_i = 0;
		#1 chk(half_high_o, 0);
		@(negedge sys_clk_i) bus_16bit_i = 1;
		rc(8'h9a, 32'hffffffff);
		#1 chk(half_high_o, 0);
		host.wr(8'h98, 32'h00000000);
		#1 chk(half_high_o, 0);
		host.rd(8'h9a, v);
		#1 chk(half_high_o, 1);
		@(negedge sys_clk_i) bus_16bit_i = 0;
		host.wr(8'h8c, 32'h20000002);
		ev;
		ev;
		chk(te - tp, 750);
		rc(8'h8c, 32'h20000002);
		host.wr(8'h8c, 32'h00000000);
		rc(8'h8c, 32'h0000ffff);
		host.rd(8'h90, v);
		repeat (300) @(negedge sys_clk_i);
		rc(8'h90, v);
		{tx_word_i, tx_word_valid_i} = {32'h22221111, 1'b1};
		@(negedge sys_clk_i) {tx_word_i, tx_word_valid_i} = 33'h0;
		chk({tx_half_valid_o, tx_half_o}, 32'h00011111);
		@(negedge sys_clk_i) chk({tx_half_valid_o, tx_half_o}, 32'h12222);
		{rx_half_i, rx_half_valid_i} = {16'haaaa, 1'b1};
		@(negedge sys_clk_i) rx_half_i = 16'hbbbb;
		@(negedge sys_clk_i) {rx_half_i, rx_half_valid_i} = {16'h4444, 1'b0};
		chk(rx_word_o, 32'hbbbbaaaa);
		chk(rx_word_valid_o, 1);
		end_of_test;
	end
endmodule // tb_timer_wordswap_cycle_regs
bind tws_regs tws_regs_chk chk (.*);

// ### bench/tws_host.sv
// Host processor model issuing register reads and writes.
`timescale 1ns/1ps
module tws_host
(
	input wire sys_clk_i,
	input wire [31:0] rdata_i,
	output reg [7:0] addr_o,
	output reg wr_o,
	output reg rd_o,
	output reg [31:0] wdata_o
);
	initial {addr_o, wr_o, rd_o, wdata_o} = 42'h0;
	task wr(input [7:0] a, input [31:0] d);
	begin
		@(negedge sys_clk_i) {addr_o, wdata_o, wr_o} = {a, d, 1'b1};
		@(negedge sys_clk_i) {wr_o, wdata_o} = {1'b0, ~d};
	end
	endtask
	task rd(input [7:0] a, output [31:0] d);
	begin
		@(negedge sys_clk_i) {addr_o, rd_o} = {a, 1'b1};
		@(negedge sys_clk_i) rd_o = 1'b0;
		@(negedge sys_clk_i) d = rdata_i;
	end
	endtask
endmodule // tws_host

// ### bench/tws_regs_chk.sv
// Concurrent checks on the register bank ports.
`timescale 1ns/1ps
module tws_regs_chk
(
	input wire sys_clk_i,
	input wire resetn_i,
	input wire bus_16bit_i,
	input wire [7:0] addr_i,
	input wire wr_i,
	input wire rd_i,
	input wire [31:0] wdata_i,
	input wire [31:0] rdata_o,
	input wire half_high_o,
	input wire [31:0] tx_word_i,
	input wire tx_word_valid_i,
	input wire tx_word_ready_o,
	input wire [15:0] tx_half_o,
	input wire tx_half_valid_o,
	input wire [15:0] rx_half_i,
	input wire rx_half_valid_i,
	input wire [31:0] rx_word_o,
	input wire rx_word_valid_o,
	input wire timer_event_o
);
	reg [31:0] ord;
	reg [31:0] tw;
	wire take = tx_word_valid_i && tx_word_ready_o;
	// Shadow copies of the word order and of the last word taken.
	always @(posedge sys_clk_i or negedge resetn_i)
		if (!resetn_i)
			ord <= 32'h00000000;
		else if (wr_i && addr_i[7:2] == 6'h26)
			ord <= wdata_i;
	always @(posedge sys_clk_i)
		if (take)
			tw <= tx_word_i;
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!resetn_i);
	wide_half_a: assert property (!bus_16bit_i |-> !half_high_o)
		else $error("half select in 32-bit mode");
	narrow_half_a: assert property (bus_16bit_i |->
		half_high_o == (addr_i[1] ^ (ord == 32'hffffffff)))
		else $error("half steering");
	tx_low_a: assert property (take |=> tx_half_valid_o && tx_half_o ==
		tw[15:0]) else $error("low half not first");
	tx_high_a: assert property (take |=> ##1 tx_half_valid_o &&
		tx_half_o == tw[31:16]) else $error("high half not second");
	rx_pair_a: assert property (rx_word_valid_o |->
		$past(rx_half_valid_i) && rx_word_o[31:16] == $past(rx_half_i))
		else $error("rx word order");
	cnt_upper_a: assert property (rd_i && addr_i == 8'h90 |=>
		rdata_o[31:16] == 16'h0000) else $error("count upper bits");
	unmap_rd_a: assert property (rd_i && addr_i == 8'h00 |=>
		rdata_o == 32'h00000000) else $error("unmapped read");
	event_pulse_a: assert property (timer_event_o |=> !timer_event_o)
		else $error("event longer than one cycle");
	cover property (timer_event_o);
	cover property (rx_word_valid_o);
	cover property (take);
	cover property (bus_16bit_i && ord == 32'hffffffff && half_high_o);
endmodule // tws_regs_chk

// ### hw/tws_consts.vh
// Register offsets, field positions, reset values and timing counts.
`ifndef TWS_CONSTS_VH
`define TWS_CONSTS_VH
`define TWS_OFF_TIMER_CONFIG 8'h8c
`define TWS_OFF_TIMER_CURRENT_VALUE 8'h90
`define TWS_OFF_HOST_WORD_ORDER 8'h98
`define TWS_OFF_ELAPSED_CYCLE_COUNTER 8'h9c
`define TWS_TIMER_RUN_BIT 29
`define TWS_PRELOAD_MSB 15
`define TWS_PRELOAD_LSB 0
`define TWS_PRELOAD_RST 16'hffff
`define TWS_COUNT_RST 16'hffff
`define TWS_WORD_ORDER_RST 32'h00000000
`define TWS_WORD_ORDER_SWAP 32'hffffffff
`define TWS_SYS_CLK_MHZ 250
`define TWS_REF_CLK_MHZ 25
`define TWS_REF_DIV 8'd10
`define TWS_RUN_RST 1'b0
`define TWS_CYCLE_RST 32'h00000000
`define TWS_TICK_DIV 8'd25
`endif

// ### hw/tws_regs.v
// Timer, word-order and elapsed-cycle register bank.
//
// Contract
// - Writing run bit one starts the timer.
// - Run bit zero halts the timer count.
// - Run bit falling edge forces preload to ones.
// - Timer loads the read-write preload field.
// - Timer raises interrupt events at preload intervals; code fires every preload+1 ticks.
// - Read-only count field, resets to ones.
// - Word order ignored in 32-bit bus mode.
// - 32-bit mode maps lines straight to halves.
// - 16-bit, not all ones: A1 selects high.
// - 16-bit, all ones: A1 selects low.
// - Transmit low half before high half.
// - First received half lands in low half.
// - 32-bit cycle counter, cleared, counts 25MHz.
// - Cycle counter wraps at maximum, no saturation.
// - First 16-bit half read latches whole count.
// - Counter may clear late after reset.
// - Cycle counter runs in all power states.
`timescale 1ns/1ps
`include "tws_consts.vh"
module tws_regs
(
	input wire sys_clk_i,
	input wire resetn_i,
	input wire bus_16bit_i,
	input wire [7:0] addr_i,
	input wire wr_i,
	input wire rd_i,
	input wire [31:0] wdata_i,
	output reg [31:0] rdata_o,
	output wire half_high_o,
	input wire [31:0] tx_word_i,
	input wire tx_word_valid_i,
	output wire tx_word_ready_o,
	output reg [15:0] tx_half_o,
	output reg tx_half_valid_o,
	input wire [15:0] rx_half_i,
	input wire rx_half_valid_i,
	output reg [31:0] rx_word_o,
	output reg rx_word_valid_o,
	output reg timer_event_o
);

	reg timer_run;
	reg [15:0] timer_preload;
	reg [15:0] timer_current_value;
	reg [31:0] host_word_order;
	reg [31:0] elapsed_cycle_count;
	reg [31:0] count_latch;
	reg latch_held;
	reg [7:0] ref_div;
	reg [7:0] tick_div;
	reg tx_second;
	reg [15:0] tx_hold;
	reg rx_second;
	reg [15:0] rx_low;
	reg [15:0] next_timer_value;
	reg next_event;
	wire ref_tick;
	wire timer_tick;
	wire wr_cfg;
	wire [31:0] cfg_view;
	wire wr_order;
	wire wr_run;
	wire [15:0] wr_preload;

	// Picks which half a 16-bit access addresses; bit one is A[1].
	// Only the exact all-ones word order swaps the halves.
	function sel_high;
		input narrow;
		input [1:0] a;
		input [31:0] order;
		begin
			if (!narrow)
				sel_high = 1'b0;
			else if (order == `TWS_WORD_ORDER_SWAP)
				sel_high = ~a[1];
			else
				sel_high = a[1];
		end
	endfunction

	// True when a byte address falls on the given register's word.
	function reg_hit;
		input [7:0] a;
		input [7:0] off;
		begin
			reg_hit = (a[7:2] == off[7:2]);
		end
	endfunction

	// In 32-bit mode the bus lines map directly, so no half is chosen.
	assign half_high_o = sel_high(bus_16bit_i, addr_i[1:0],
		host_word_order);

	assign ref_tick = (ref_div == (`TWS_REF_DIV - 8'd1));
	// One tick is 25 reference cycles, so the count steps once a microsecond.
	assign timer_tick = ref_tick && (tick_div == (`TWS_TICK_DIV - 8'd1));
	assign wr_cfg = wr_i && reg_hit(addr_i, `TWS_OFF_TIMER_CONFIG);
	assign wr_order = wr_i && reg_hit(addr_i, `TWS_OFF_HOST_WORD_ORDER);
	assign wr_run = wdata_i[`TWS_TIMER_RUN_BIT];
	assign wr_preload = wdata_i[`TWS_PRELOAD_MSB:`TWS_PRELOAD_LSB];
	assign cfg_view = {2'b00, timer_run, 13'h0000, timer_preload};

	// Reference divider: 25 MHz from the 250 MHz system clock.
	always @(posedge sys_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			ref_div <= 8'h00;
			tick_div <= 8'h00;
		end
		else
		begin
			if (ref_tick)
				ref_div <= 8'h00;
			else
				ref_div <= ref_div + 8'h01;
			if (timer_tick)
				tick_div <= 8'h00;
			else if (ref_tick)
				tick_div <= tick_div + 8'h01;
		end
	end

	// Counts regardless of any power state; wraps at its maximum.
	// It clears at once on reset, well inside the allowed settling time.
	always @(posedge sys_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			elapsed_cycle_count <= `TWS_CYCLE_RST;
		else if (ref_tick)
			elapsed_cycle_count <= elapsed_cycle_count + 32'h00000001;
	end

	// Timer configuration register.
	always @(posedge sys_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			timer_run <= `TWS_RUN_RST;
			timer_preload <= `TWS_PRELOAD_RST;
		end
		else if (wr_cfg)
		begin
			timer_run <= wr_run;
			if (timer_run && !wr_run)
				timer_preload <= `TWS_PRELOAD_RST;
			else
				timer_preload <= wr_preload;
		end
	end

	// Word-order control; read back at its offset, and used only by the 16-bit half steering.
	always @(posedge sys_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			host_word_order <= `TWS_WORD_ORDER_RST;
		else if (wr_order)
			host_word_order <= wdata_i;
	end

	// Next timer value: halted unless running, reload at zero.
	// Starting from halt loads the written preload at once.
	always @*
	begin
		next_timer_value = timer_current_value;
		next_event = 1'b0;
		if (wr_cfg && wr_run && !timer_run)
			next_timer_value = wr_preload;
		else if (timer_run && timer_tick)
		begin
			if (timer_current_value == 16'h0000)
			begin
				next_timer_value = timer_preload;
				next_event = 1'b1;
			end
			else
				next_timer_value = timer_current_value - 16'h0001;
		end
	end

	// Timer count and its one-cycle event pulse.
	always @(posedge sys_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			timer_current_value <= `TWS_COUNT_RST;
			timer_event_o <= 1'b0;
		end
		else
		begin
			timer_current_value <= next_timer_value;
			timer_event_o <= next_event;
		end
	end

	// Register reads; the cycle count latches on the first half read.
	always @(posedge sys_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			rdata_o <= 32'h00000000;
			count_latch <= 32'h00000000;
			latch_held <= 1'b0;
		end
		else if (rd_i)
		begin
			case ({addr_i[7:2], 2'b00})
			`TWS_OFF_TIMER_CONFIG:
				rdata_o <= cfg_view;
			`TWS_OFF_TIMER_CURRENT_VALUE:
				rdata_o <= {16'h0000, timer_current_value};
			`TWS_OFF_HOST_WORD_ORDER:
				rdata_o <= host_word_order;
			// A 16-bit host reads the count in two halves; latching on the
			// first read keeps both halves from the same instant.
			`TWS_OFF_ELAPSED_CYCLE_COUNTER:
			begin
				if (!bus_16bit_i)
					rdata_o <= elapsed_cycle_count;
				else if (!latch_held)
				begin
					count_latch <= elapsed_cycle_count;
					latch_held <= 1'b1;
					rdata_o <= elapsed_cycle_count;
				end
				else
				begin
					latch_held <= 1'b0;
					rdata_o <= count_latch;
				end
			end
			// Unmapped offsets read as zero.
			default:
				rdata_o <= 32'h00000000;
			endcase
		end
	end

	// Transmit side: low half first, then high half.
	// Ready stays low while the high half waits in tx_hold, so words never overlap.
	assign tx_word_ready_o = !tx_second;

	always @(posedge sys_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			tx_second <= 1'b0;
			tx_hold <= 16'h0000;
			tx_half_o <= 16'h0000;
			tx_half_valid_o <= 1'b0;
		end
		else
		begin
			tx_half_valid_o <= 1'b0;
			if (tx_second)
			begin
				tx_half_o <= tx_hold;
				tx_half_valid_o <= 1'b1;
				tx_second <= 1'b0;
			end
			else if (tx_word_valid_i)
			begin
				tx_half_o <= tx_word_i[15:0];
				tx_hold <= tx_word_i[31:16];
				tx_half_valid_o <= 1'b1;
				tx_second <= 1'b1;
			end
		end
	end

	// Receive side: first half goes low, second half completes word.
	// A lone half waits for its partner for as long as it takes.
	always @(posedge sys_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			rx_second <= 1'b0;
			rx_low <= 16'h0000;
			rx_word_o <= 32'h00000000;
			rx_word_valid_o <= 1'b0;
		end
		else
		begin
			rx_word_valid_o <= 1'b0;
			if (rx_half_valid_i)
			begin
				if (!rx_second)
					rx_low <= rx_half_i;
				else
				begin
					rx_word_o <= {rx_half_i, rx_low};
					rx_word_valid_o <= 1'b1;
				end
				rx_second <= ~rx_second;
			end
		end
	end

endmodule // tws_regs
